// File: logic/sidl_top.sv
// Interrupt, DMA request and slave select low detection of a serial unit.
// Assumes an APB master, a serial core on pclk and an async select pin.
//
// Our own choice: the APB register port.
`timescale 1ns/1ps
`default_nettype none

`include "sidl_params.svh"

module sidl_top (
  // Clock, reset and clock enable
  input wire logic pclk,
  input wire logic presetn,
  input wire logic pce,
  // APB slave
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [7:0] paddr,
  input wire logic [31:0] pwdata,
  output logic [31:0] prdata,
  output logic pready,
  output logic pslverr,
  // Serial core status and events
  input wire logic tx_buf_empty,
  input wire logic rx_data_avail,
  input wire logic [31:0] rx_data,
  input wire logic tx_complete_evt,
  input wire logic collision_err,
  input wire logic sync_field_err,
  input wire logic buffer_overflow,
  input wire logic frame_err,
  input wire logic parity_err,
  input wire logic ss_drive_req,
  // Serial core data strobes
  output logic [31:0] tx_data,
  output logic tx_wr,
  output logic rx_rd,
  // Slave select pin
  input wire logic ss_n_i,
  output logic ss_n_o,
  output logic ss_n_oe,
  // Requests
  output logic irq,
  output logic wake,
  output logic dma_rx_req,
  output logic dma_tx_req
);
  import sidl_pkg::*;

  // ****************************************************************
  // Helpers
  // ****************************************************************
  function automatic logic hit(input logic [7:0] a, input logic [7:0] off);
    hit = (a == off);
  endfunction : hit

  // Sticky flag update: a set in the same cycle wins over a clear.
  function automatic logic [7:0] w1c(input logic [7:0] cur, input logic [7:0] set,
                                     input logic [7:0] clr);
    w1c = set | (cur & ~clr);
  endfunction : w1c

  // ****************************************************************
  // State
  // ****************************************************************
  sidl_state_s q;
  sidl_state_s n;
  logic ss_lvl;
  logic setup;
  logic acc_done;
  logic wr_acc;
  logic rd_acc;
  logic mapped;
  logic ss_fall;
  logic [4:0] err_evt;
  logic [7:0] flag_view;
  logic [7:0] pend;
  logic [7:0] set_v;
  logic [7:0] clr_v;
  logic [7:0] err_v;

  sidl_sync u_ss_sync (
    .pclk(pclk),
    .presetn(presetn),
    .pce(pce),
    .pin_i(ss_n_i),
    .level_r(ss_lvl)
  );

  // ****************************************************************
  // Next state
  // ****************************************************************
  always_comb begin
    n = q;
    err_evt = {parity_err, frame_err, buffer_overflow, sync_field_err, collision_err};
    setup = psel && !penable;
    acc_done = psel && penable && q.pready;
    wr_acc = acc_done && pwrite && !q.pslverr;
    rd_acc = acc_done && !pwrite && !q.pslverr;
    mapped = hit(paddr, `SIDL_OFF_CTRL) || hit(paddr, `SIDL_OFF_EN_CLR)
      || hit(paddr, `SIDL_OFF_EN_SET) || hit(paddr, `SIDL_OFF_FLAG)
      || hit(paddr, `SIDL_OFF_FLAG_CLR) || hit(paddr, `SIDL_OFF_ERR_STAT)
      || hit(paddr, `SIDL_OFF_DATA);
    // Empty and receive positions mirror the core directly.
    flag_view = q.flag & `SIDL_STICKY_MASK;
    flag_view[`SIDL_BIT_DATA_REG_EMPTY] = tx_buf_empty;
    flag_view[`SIDL_BIT_RX_COMPLETE] = rx_data_avail;
    pend = flag_view & q.int_en;
    // A falling select counts only in slave mode with detection on.
    ss_fall = q.ss_prev && !ss_lvl && q.ctrl[`SIDL_CTRL_SLAVE_MODE]
      && q.ctrl[`SIDL_CTRL_SS_LOW_DETECT_EN];
    set_v = `SIDL_RST_BYTE;
    set_v[`SIDL_BIT_TX_COMPLETE] = tx_complete_evt;
    set_v[`SIDL_BIT_SS_LOW] = ss_fall;
    set_v[`SIDL_BIT_ERROR] = |err_evt;
    clr_v = `SIDL_RST_BYTE;
    if (wr_acc && (hit(paddr, `SIDL_OFF_FLAG) || hit(paddr, `SIDL_OFF_FLAG_CLR))) begin
      clr_v = pwdata[7:0] & `SIDL_STICKY_MASK;
    end
    err_v = `SIDL_RST_BYTE;
    if (wr_acc && hit(paddr, `SIDL_OFF_ERR_STAT)) begin
      err_v = pwdata[7:0] & `SIDL_ERR_MASK;
    end

    n.ss_prev = ss_lvl;
    n.flag = w1c(q.flag, set_v, clr_v) & `SIDL_STICKY_MASK;
    n.err_stat = w1c(q.err_stat, {3'h0, err_evt}, err_v) & `SIDL_ERR_MASK;
    n.tx_wr = 1'b0;
    n.rx_rd = 1'b0;

    // APB: ready one cycle after setup, no wait states.
    case (q.apb_st)
      SIDL_APB_IDLE: begin
        n.pready = 1'b0;
        if (setup) begin
          n.apb_st = SIDL_APB_ACCESS;
          n.pready = 1'b1;
          n.pslverr = !mapped;
          n.prdata = `SIDL_RST_WORD;
          if (!pwrite) begin
            if (hit(paddr, `SIDL_OFF_CTRL)) begin
              n.prdata[`SIDL_CTRL_W-1:0] = q.ctrl;
            end else if (hit(paddr, `SIDL_OFF_EN_CLR) || hit(paddr, `SIDL_OFF_EN_SET)) begin
              n.prdata[7:0] = q.int_en;
            end else if (hit(paddr, `SIDL_OFF_FLAG)) begin
              n.prdata[7:0] = flag_view;
            end else if (hit(paddr, `SIDL_OFF_ERR_STAT)) begin
              n.prdata[7:0] = q.err_stat;
            end else if (hit(paddr, `SIDL_OFF_DATA)) begin
              n.prdata = rx_data;
            end
          end
        end
      end
      SIDL_APB_ACCESS: begin
        n.pready = 1'b0;
        n.pslverr = 1'b0;
        n.apb_st = SIDL_APB_IDLE;
        if (wr_acc) begin
          if (hit(paddr, `SIDL_OFF_CTRL)) begin
            n.ctrl = pwdata[`SIDL_CTRL_W-1:0];
          end else if (hit(paddr, `SIDL_OFF_EN_SET)) begin
            n.int_en = q.int_en | (pwdata[7:0] & `SIDL_IRQ_MASK);
          end else if (hit(paddr, `SIDL_OFF_EN_CLR)) begin
            n.int_en = q.int_en & ~(pwdata[7:0] & `SIDL_IRQ_MASK);
          end else if (hit(paddr, `SIDL_OFF_DATA)) begin
            n.tx_wr = 1'b1;
            n.tx_data = pwdata;
          end
        end
        if (rd_acc && hit(paddr, `SIDL_OFF_DATA)) begin
          n.rx_rd = 1'b1;
        end
      end
      default: begin
        n.apb_st = SIDL_APB_IDLE;
        n.pready = 1'b0;
      end
    endcase

    // Interrupt and wake stand while an enabled flag is set.
    n.irq = |pend;
    n.wake = |pend;
    // Only the receive and empty conditions request DMA.
    n.dma_rx = rx_data_avail && !n.rx_rd && !q.rx_rd;
    n.dma_tx = tx_buf_empty && !n.tx_wr && !q.tx_wr;
    // Select is driven only in master mode with hardware select.
    n.ss_oe = !q.ctrl[`SIDL_CTRL_SLAVE_MODE] && q.ctrl[`SIDL_CTRL_MASTER_SS_HW_EN];
    n.ss_o = !ss_drive_req;
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      q <= '0;
      q.apb_st <= SIDL_APB_IDLE;
      q.ss_prev <= `SIDL_SS_IDLE;
      q.ss_o <= `SIDL_SS_IDLE;
    end else if (pce) begin
      q <= n;
    end
  end

  // ****************************************************************
  // Outputs
  // ****************************************************************
  assign prdata = q.prdata;
  assign pready = q.pready;
  assign pslverr = q.pslverr;
  assign tx_data = q.tx_data;
  assign tx_wr = q.tx_wr;
  assign rx_rd = q.rx_rd;
  assign ss_n_o = q.ss_o;
  assign ss_n_oe = q.ss_oe;
  assign irq = q.irq;
  assign wake = q.wake;
  assign dma_rx_req = q.dma_rx;
  assign dma_tx_req = q.dma_tx;

  // ****************************************************************
  // Checks
  // ****************************************************************
  default clocking cb @(posedge pclk);
  endclocking
  default disable iff (!presetn);

  property p_en_set;
    pce && wr_acc && hit(paddr, `SIDL_OFF_EN_SET)
      |=> q.int_en == ($past(q.int_en) | ($past(pwdata[7:0]) & `SIDL_IRQ_MASK));
  endproperty
  a_en_set: assert property (p_en_set) else $error("enable set wrong");

  property p_en_clr;
    pce && wr_acc && hit(paddr, `SIDL_OFF_EN_CLR)
      |=> q.int_en == ($past(q.int_en) & ~$past(pwdata[7:0]));
  endproperty
  a_en_clr: assert property (p_en_clr) else $error("enable clear wrong");

  property p_err_keep;
    pce && q.flag[`SIDL_BIT_ERROR] && !clr_v[`SIDL_BIT_ERROR] |=> q.flag[`SIDL_BIT_ERROR];
  endproperty
  a_err_keep: assert property (p_err_keep) else $error("error flag lost");

  property p_err_set;
    pce && (|err_evt) |=> q.flag[`SIDL_BIT_ERROR] && (q.err_stat[4:0] != 5'h00);
  endproperty
  a_err_set: assert property (p_err_set) else $error("error not flagged");

  property p_err_win;
    pce && (|err_evt) && clr_v[`SIDL_BIT_ERROR] |=> q.flag[`SIDL_BIT_ERROR];
  endproperty
  a_err_win: assert property (p_err_win) else $error("clear beat error set");

  property p_ss_set;
    pce && ss_fall |=> q.flag[`SIDL_BIT_SS_LOW];
  endproperty
  a_ss_set: assert property (p_ss_set) else $error("select low not flagged");

  property p_ss_off;
    pce && !q.ctrl[`SIDL_CTRL_SS_LOW_DETECT_EN] && !q.flag[`SIDL_BIT_SS_LOW]
      |=> !q.flag[`SIDL_BIT_SS_LOW];
  endproperty
  a_ss_off: assert property (p_ss_off) else $error("select low set while off");

  property p_rx_drop;
    pce && rd_acc && hit(paddr, `SIDL_OFF_DATA) |=> !dma_rx_req && rx_rd;
  endproperty
  a_rx_drop: assert property (p_rx_drop) else $error("rx request not dropped");

  property p_tx_drop;
    pce && wr_acc && hit(paddr, `SIDL_OFF_DATA) |=> !dma_tx_req && tx_wr;
  endproperty
  a_tx_drop: assert property (p_tx_drop) else $error("tx request not dropped");

  property p_rx_none;
    pce && !rx_data_avail |=> !dma_rx_req;
  endproperty
  a_rx_none: assert property (p_rx_none) else $error("rx request without data");

  property p_rx_up;
    pce && rx_data_avail && !q.rx_rd
      && !(rd_acc && hit(paddr, `SIDL_OFF_DATA)) |=> dma_rx_req;
  endproperty
  a_rx_up: assert property (p_rx_up) else $error("rx request missing");

  property p_tx_none;
    pce && !tx_buf_empty |=> !dma_tx_req;
  endproperty
  a_tx_none: assert property (p_tx_none) else $error("tx request while full");

  property p_tx_up;
    pce && tx_buf_empty && !q.tx_wr
      && !(wr_acc && hit(paddr, `SIDL_OFF_DATA)) |=> dma_tx_req;
  endproperty
  a_tx_up: assert property (p_tx_up) else $error("tx request missing");

  property p_dma_src;
    pce && !rx_data_avail && !tx_buf_empty |=> !dma_rx_req && !dma_tx_req;
  endproperty
  a_dma_src: assert property (p_dma_src) else $error("dma without source");

  property p_irq;
    pce |=> irq == |($past(flag_view) & $past(q.int_en));
  endproperty
  a_irq: assert property (p_irq) else $error("interrupt level wrong");

  property p_wake;
    pce |=> wake == |($past(flag_view) & $past(q.int_en));
  endproperty
  a_wake: assert property (p_wake) else $error("wake differs");

  property p_flag_view;
    pce && setup && !pwrite && hit(paddr, `SIDL_OFF_FLAG)
      |=> prdata[`SIDL_BIT_DATA_REG_EMPTY] == $past(tx_buf_empty)
        && prdata[`SIDL_BIT_RX_COMPLETE] == $past(rx_data_avail);
  endproperty
  a_flag_view: assert property (p_flag_view) else $error("flag view wrong");

  property p_txc;
    pce && tx_complete_evt |=> q.flag[`SIDL_BIT_TX_COMPLETE];
  endproperty
  a_txc: assert property (p_txc) else $error("tx complete not flagged");

  property p_ss_drive;
    pce && q.ctrl[`SIDL_CTRL_SLAVE_MODE] |=> !ss_n_oe;
  endproperty
  a_ss_drive: assert property (p_ss_drive) else $error("select driven in slave");

  property p_oe_master;
    pce && !q.ctrl[`SIDL_CTRL_SLAVE_MODE] && q.ctrl[`SIDL_CTRL_MASTER_SS_HW_EN]
      |=> ss_n_oe && (ss_n_o == !$past(ss_drive_req));
  endproperty
  a_oe_master: assert property (p_oe_master) else $error("select not driven");

  property p_freeze;
    !pce |=> q == $past(q);
  endproperty
  a_freeze: assert property (p_freeze) else $error("state moved while frozen");

  property p_apb_ready;
    pce && setup && q.apb_st == SIDL_APB_IDLE |=> pready ##1 !pready;
  endproperty
  a_apb_ready: assert property (p_apb_ready) else $error("apb ready timing");

  c_irq: cover property (pce && irq);
  c_ss_fall: cover property (pce && ss_fall);
  c_dma_rx: cover property (pce && dma_rx_req ##1 rx_rd);
  c_err: cover property (pce && (|err_evt) && clr_v[`SIDL_BIT_ERROR]);

endmodule : sidl_top

`default_nettype wire

// File: logic/sidl_params.svh
// Register offsets, field positions, masks and reset values of the serial
// interrupt and DMA request block.
// Assumes inclusion by bare name from the package and design modules.
//
// Notes on behaviour
// - Enable-set writes of one enable receive/transmit/empty.
// - Error flag clears only on written one.
// - Any detected error sets the error flag.
// - Enabled slave select fall sets flag, wakes.
// - Receive request while data waits, dropped on read.
// - Transmit request while buffer empty, dropped on write.
// - Only empty and receive raise DMA; no events.
// - All five sources can wake the device.
// - Each source owns one flag, set on condition.
// - Request stands while flag and enable set.
// - Enable-clear writes of one disable; shared state.
`ifndef SIDL_PARAMS_SVH
`define SIDL_PARAMS_SVH

// ****************************************************************
// Register byte offsets
// ****************************************************************
`define SIDL_OFF_CTRL 8'h00
`define SIDL_OFF_EN_CLR 8'h10
`define SIDL_OFF_EN_SET 8'h14
`define SIDL_OFF_FLAG 8'h18
`define SIDL_OFF_FLAG_CLR 8'h1c
`define SIDL_OFF_ERR_STAT 8'h20
`define SIDL_OFF_DATA 8'h28

// ****************************************************************
// Flag and enable bit positions
// ****************************************************************
`define SIDL_BIT_DATA_REG_EMPTY 0
`define SIDL_BIT_TX_COMPLETE 1
`define SIDL_BIT_RX_COMPLETE 2
`define SIDL_BIT_SS_LOW 3
`define SIDL_BIT_ERROR 7

// ****************************************************************
// Control bit positions
// ****************************************************************
`define SIDL_CTRL_SS_LOW_DETECT_EN 0
`define SIDL_CTRL_SLAVE_MODE 1
`define SIDL_CTRL_MASTER_SS_HW_EN 2

// ****************************************************************
// Masks, widths and reset values
// ****************************************************************
`define SIDL_IRQ_MASK 8'h8f
`define SIDL_STICKY_MASK 8'h8a
`define SIDL_ERR_MASK 8'h1f
`define SIDL_CTRL_W 3
`define SIDL_ERR_W 5
`define SIDL_RST_BYTE 8'h00
`define SIDL_RST_WORD 32'h0000_0000
`define SIDL_RST_CTRL 3'h0
`define SIDL_SS_IDLE 1'b1
`define SIDL_SS_IDLE_STG 3'h7

`endif

// File: logic/sidl_pkg.sv
// Types shared by the serial interrupt and DMA request block.
// Assumes the params header is on the include path.
`default_nettype none

`include "sidl_params.svh"

package sidl_pkg;

  typedef enum logic [0:0] {
    SIDL_APB_IDLE,
    SIDL_APB_ACCESS
  } sidl_apb_e;

  typedef struct packed {
    sidl_apb_e apb_st;
    logic pready;
    logic pslverr;
    logic [31:0] prdata;
    logic [`SIDL_CTRL_W-1:0] ctrl;
    logic [7:0] int_en;
    logic [7:0] flag;
    logic [7:0] err_stat;
    logic ss_prev;
    logic irq;
    logic wake;
    logic dma_rx;
    logic dma_tx;
    logic [31:0] tx_data;
    logic tx_wr;
    logic rx_rd;
    logic ss_o;
    logic ss_oe;
  } sidl_state_s;

endpackage : sidl_pkg

`default_nettype wire

// File: logic/sidl_sync.sv
// Three-stage synchroniser for a pin input with an agreement filter.
// Assumes the input is asynchronous to pclk.
`timescale 1ns/1ps
`default_nettype none

`include "sidl_params.svh"

module sidl_sync (
  // Clock and reset
  input wire logic pclk,
  input wire logic presetn,
  input wire logic pce,
  // Pin and result
  input wire logic pin_i,
  output logic level_r
);

  // ****************************************************************
  // Synchroniser stages
  // ****************************************************************
  logic [2:0] stg_r;

  // The level follows only once the second and third stages agree.
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      stg_r <= `SIDL_SS_IDLE_STG;
      level_r <= `SIDL_SS_IDLE;
    end else if (pce) begin
      stg_r <= {stg_r[1:0], pin_i};
      if (stg_r[1] == stg_r[2]) begin
        level_r <= stg_r[2];
      end
    end
  end

endmodule : sidl_sync

`default_nettype wire

// File: dv/sidl_spi_partner.sv
// Far side of the select pin: an SPI master framing with select and clock.
// Assumes the bench resolves the select wire with a pull-up.
`timescale 1ns/1ps
`default_nettype none

module sidl_spi_partner (
  // Link pins
  output logic sck,
  output logic ss_drv_en,
  output logic ss_drv_val
);
  // ****************************************************************
  // Framing
  // ****************************************************************
  initial begin
    sck = 1'b0;
    ss_drv_en = 1'b0;
    ss_drv_val = 1'b1;
  end

  // Select falls, the clock runs only inside the frame, then the line is let go.
  task automatic frame(input int bits);
    #3;
    ss_drv_en = 1'b1;
    ss_drv_val = 1'b0;
    repeat (bits * 2) #80 sck = ~sck;
    #80 ss_drv_val = 1'b1;
    ss_drv_en = 1'b0;
  endtask : frame
endmodule : sidl_spi_partner

`default_nettype wire

// File: dv/testbench.sv
// Bench for the serial interrupt and DMA request block over APB.
// Assumes the params header on the include path; pce is held high except for the freeze step.
`timescale 1ns/1ps
`default_nettype none

`include "sidl_params.svh"

module testbench;
  logic pclk, presetn, pce, psel, penable, pwrite, tx_buf_empty, rx_data_avail, ss_drive_req;
  logic [7:0] paddr;
  logic [31:0] pwdata, prdata, rx_data, tx_data, r;
  logic pready, pslverr, tx_wr, rx_rd, ss_n_o, ss_n_oe, irq, wake, dma_rx_req, dma_tx_req;
  logic sck, ss_drv_en, ss_drv_val, ss_line, e;
  logic [5:0] ev;
  int fails, num_checks, cyc;

  // Pull-up on the select wire when nobody drives it.
  assign ss_line = ss_n_oe ? ss_n_o : (ss_drv_en ? ss_drv_val : 1'b1);

  sidl_spi_partner u_sidl_spi_partner (.sck(sck), .ss_drv_en(ss_drv_en),
    .ss_drv_val(ss_drv_val));
  sidl_top u_sidl_top (.pclk(pclk), .presetn(presetn), .pce(pce), .psel(psel),
    .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata),
    .pready(pready), .pslverr(pslverr), .tx_buf_empty(tx_buf_empty),
    .rx_data_avail(rx_data_avail), .rx_data(rx_data), .tx_complete_evt(ev[5]),
    .collision_err(ev[0]), .sync_field_err(ev[1]), .buffer_overflow(ev[2]),
    .frame_err(ev[3]), .parity_err(ev[4]), .ss_drive_req(ss_drive_req),
    .tx_data(tx_data), .tx_wr(tx_wr), .rx_rd(rx_rd), .ss_n_i(ss_line), .ss_n_o(ss_n_o),
    .ss_n_oe(ss_n_oe), .irq(irq), .wake(wake), .dma_rx_req(dma_rx_req),
    .dma_tx_req(dma_tx_req));

  // ****************************************************************
  // Tasks
  // ****************************************************************
  task automatic final_report;
    $display("checks %0d mismatches %0d", num_checks, fails);
    if (fails == 0 && num_checks > 0) $display("[ PASS ]");
    else $display("[ FAIL ]");
    $finish;
  endtask : final_report

  task automatic chk(input string nm, input logic [31:0] x, input logic [31:0] g);
    num_checks++;
    if (g !== x) begin
      fails++;
      $display("MISMATCH %s expected %h seen %h", nm, x, g);
    end
  endtask : chk

  task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] d);
    @(posedge pclk);
    psel <= 1'b1;
    penable <= 1'b0;
    pwrite <= w;
    paddr <= a;
    pwdata <= d;
    @(posedge pclk);
    penable <= 1'b1;
    @(posedge pclk);
    while (pready !== 1'b1) @(posedge pclk);
    r = prdata;
    e = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
  endtask : apb

  task automatic rd(input logic [7:0] a, input logic [31:0] x, input string nm);
    apb(1'b0, a, 32'h0000_0000);
    chk(nm, x, r);
  endtask : rd

  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    apb(1'b1, a, d);
  endtask : wr

  task automatic settle;
    repeat (2) @(posedge pclk);
    #1;
  endtask : settle

  task automatic pulse(input int i);
    @(posedge pclk) ev[i] <= 1'b1;
    @(posedge pclk) ev[i] <= 1'b0;
  endtask : pulse

  // ****************************************************************
  // Clock, reset and timeout
  // ****************************************************************
  initial begin
    pclk = 1'b0;
    forever #5 pclk = ~pclk;
  end

  always @(posedge pclk) begin
    cyc++;
    if (cyc > 20000) begin
      fails++;
      final_report();
    end
  end

  // ****************************************************************
  // Tests
  // ****************************************************************
  initial begin
    {presetn, psel, penable, pwrite, tx_buf_empty, rx_data_avail, ss_drive_req} = 7'h0;
    {paddr, pwdata, rx_data, ev} = '0;
    pce = 1'b1;
    repeat (8) @(posedge pclk);
    presetn <= 1'b1;
    rd(`SIDL_OFF_FLAG, 32'h0000_0000, "flag_reset");
    rd(`SIDL_OFF_EN_SET, 32'h0000_0000, "enable_reset");
    wr(`SIDL_OFF_EN_SET, 32'h0000_0007);
    wr(`SIDL_OFF_EN_SET, 32'h0000_0000);
    rd(`SIDL_OFF_EN_SET, 32'h0000_0007, "enable_set");
    wr(`SIDL_OFF_EN_CLR, 32'h0000_0005);
    rd(`SIDL_OFF_EN_CLR, 32'h0000_0002, "enable_clear");
    wr(`SIDL_OFF_EN_CLR, 32'h0000_008f);
    @(posedge pclk) tx_buf_empty <= 1'b1;
    rd(`SIDL_OFF_FLAG, 32'h0000_0001, "empty_live");
    chk("irq_masked", 0, irq);
    wr(`SIDL_OFF_EN_SET, 32'h0000_0001);
    wr(`SIDL_OFF_FLAG, 32'h0000_0005);
    rd(`SIDL_OFF_FLAG, 32'h0000_0001, "empty_write");
    chk("irq_empty", 1, irq);
    wr(`SIDL_OFF_EN_CLR, 32'h0000_0001);
    settle();
    chk("irq_disabled", 0, irq);
    @(posedge pclk) tx_buf_empty <= 1'b0;
    $display("test enables done");
    wr(`SIDL_OFF_EN_SET, 32'h0000_0080);
    for (int i = 0; i < 5; i++) begin
      pulse(i);
      rd(`SIDL_OFF_FLAG, 32'h0000_0080, "error_set");
      rd(`SIDL_OFF_ERR_STAT, 32'h1 << i, "error_status");
      chk("error_wake", 1, wake);
      chk("error_no_dma", 0, dma_rx_req | dma_tx_req);
      wr(`SIDL_OFF_FLAG, 32'h0000_0000);
      rd(`SIDL_OFF_FLAG, 32'h0000_0080, "error_keep");
      wr(`SIDL_OFF_FLAG, 32'h0000_0080);
      wr(`SIDL_OFF_ERR_STAT, 32'h1 << i);
      rd(`SIDL_OFF_FLAG, 32'h0000_0000, "error_clear");
      chk("error_irq_off", 0, irq);
    end
    pulse(5);
    rd(`SIDL_OFF_FLAG, 32'h0000_0002, "tx_complete");
    wr(`SIDL_OFF_FLAG_CLR, 32'h0000_0002);
    rd(`SIDL_OFF_FLAG, 32'h0000_0000, "tx_complete_clear");
    wr(`SIDL_OFF_EN_CLR, 32'h0000_0080);
    @(posedge pclk) pce <= 1'b0;
    pulse(0);
    @(posedge pclk) pce <= 1'b1;
    rd(`SIDL_OFF_FLAG, 32'h0000_0000, "freeze_flag");
    rd(`SIDL_OFF_ERR_STAT, 32'h0000_0000, "freeze_status");
    $display("test errors done");
    wr(`SIDL_OFF_CTRL, 32'h0000_0002);
    wr(`SIDL_OFF_EN_SET, 32'h0000_0008);
    u_sidl_spi_partner.frame(4);
    rd(`SIDL_OFF_FLAG, 32'h0000_0000, "select_off");
    chk("select_off_wake", 0, wake);
    wr(`SIDL_OFF_CTRL, 32'h0000_0003);
    u_sidl_spi_partner.frame(4);
    rd(`SIDL_OFF_FLAG, 32'h0000_0008, "select_low");
    chk("select_wake", 1, wake);
    chk("select_no_dma", 0, dma_rx_req | dma_tx_req);
    wr(`SIDL_OFF_FLAG, 32'h0000_0008);
    wr(`SIDL_OFF_EN_CLR, 32'h0000_0008);
    $display("test select done");
    @(posedge pclk) begin
      rx_data <= 32'ha5a5_0f0f;
      rx_data_avail <= 1'b1;
    end
    settle();
    chk("dma_rx_up", 1, dma_rx_req);
    rd(`SIDL_OFF_FLAG, 32'h0000_0004, "rx_live");
    rd(`SIDL_OFF_DATA, 32'ha5a5_0f0f, "rx_word");
    #1;
    chk("rx_strobe", 1, rx_rd);
    chk("dma_rx_down", 0, dma_rx_req);
    @(posedge pclk) rx_data_avail <= 1'b0;
    @(posedge pclk) tx_buf_empty <= 1'b1;
    settle();
    chk("dma_tx_up", 1, dma_tx_req);
    wr(`SIDL_OFF_DATA, 32'h3c3c_1234);
    #1;
    chk("tx_strobe", 1, tx_wr);
    chk("tx_word", 32'h3c3c_1234, tx_data);
    chk("dma_tx_down", 0, dma_tx_req);
    @(posedge pclk) tx_buf_empty <= 1'b0;
    apb(1'b0, 8'h3c, 32'h0000_0000);
    chk("unmapped", 1, e);
    $display("test dma done");
    wr(`SIDL_OFF_CTRL, 32'h0000_0000);
    @(posedge pclk) ss_drive_req <= 1'b1;
    settle();
    chk("select_sw_owned", 0, ss_n_oe);
    wr(`SIDL_OFF_CTRL, 32'h0000_0004);
    settle();
    chk("select_hw_driven", 0, ss_line);
    $display("test select ownership done");
    final_report();
  end
endmodule : testbench

`default_nettype wire
